// ---- hdl/edge_line_event_controller.sv ----
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - nineteen independent edge lines, each raising interrupt or event requests.
// - per line, software picks rising, falling or both edges.
// - each line has its own masks; masked lines forward nothing but the overrun status bit.
// - one readable pending bit per line records a selected edge.
// - edges are caught even for pulses shorter than a clock period.
// - sixteen lines each take a chosen pin; fifty-one pins reachable.
// - lines 16 to 18 come from supply monitor, alarm, bus wakeup.
// - any detected edge can wake the chip; capture needs no clock.
module edge_line_event_controller
  import elec_pkg::*;
#(
  parameter int NUM_PINS = PIN_COUNT
) (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // register port
  input  wire logic [ADDR_W-1:0]     i_addr,
  input  wire logic [DATA_W-1:0]     i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic      [DATA_W-1:0]     o_rdata,
  // line sources
  input  wire logic [NUM_PINS-1:0]   i_gpio,
  input  wire logic                  i_supply_monitor,
  input  wire logic                  i_rtc_alarm,
  input  wire logic                  i_bus_wakeup,
  // requests
  output logic      [LINE_COUNT-1:0] o_line_irq,
  output logic      [LINE_COUNT-1:0] o_event,
  output logic                       o_wakeup,
  output logic                       o_irq
);

  // ==========================================================================
  // registers and nets
  logic [LINE_COUNT-1:0] int_mask;
  logic [LINE_COUNT-1:0] evt_mask;
  logic [LINE_COUNT-1:0] rise_sel;
  logic [LINE_COUNT-1:0] fall_sel;
  logic [LINE_COUNT-1:0] pending;
  logic [DATA_W-1:0]     port_sel;
  logic [STAT_W-1:0]     status;
  logic [STAT_W-1:0]     stat_mask;
  logic [LINE_COUNT-1:0] edge_hit;
  logic [LINE_COUNT-1:0] next_pending;
  logic [STAT_W-1:0]     next_status;
  logic [STAT_W-1:0]     next_stat_mask;

  capture_if #(.N(LINE_COUNT)) cap_bus ();

  // ==========================================================================
  // decode helpers
  function automatic logic wr_hit(input logic [ADDR_W-1:0] off);
    return i_wr && (i_addr == off);
  endfunction : wr_hit

  // read strobe aimed at one register
  function automatic logic rd_hit(input logic [ADDR_W-1:0] off);
    return i_rd && (i_addr == off);
  endfunction : rd_hit

  function automatic logic pin_of(input logic [NUM_PINS-1:0] pins,
                                  input logic [PORT_SEL_W-1:0] grp,
                                  input int line);
    int idx;
    idx = int'(grp) * EXT_LINES + line;
    return (idx < NUM_PINS) ? pins[idx] : 1'b0;   // beyond last pin reads low
  endfunction : pin_of

  // ==========================================================================
  // line sources
  // external lines: pin number = group * 16 + line
  for (genvar g = 0; g < EXT_LINES; g++) begin : g_ext
    assign cap_bus.line[g] = pin_of(i_gpio, port_sel[g*PORT_SEL_W +: PORT_SEL_W], g);
  end

  // internal lines, plain levels taken like any pin
  assign cap_bus.line[LINE_SUPPLY] = i_supply_monitor;
  assign cap_bus.line[LINE_ALARM]  = i_rtc_alarm;
  assign cap_bus.line[LINE_BUSWK]  = i_bus_wakeup;

  // asynchronous capture and crossing
  // toggles run on the line itself, so a wakeup edge is held
  // while the bus clock is stopped
  edge_capture #(
    .N     (LINE_COUNT)
  ) u_capture (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .cap   (cap_bus)
  );

  // ==========================================================================
  // edge selection and pending
  // per-line trigger choice, both selects set gives both edges
  for (genvar g = 0; g < LINE_COUNT; g++) begin : g_sel
    assign edge_hit[g] = (cap_bus.rise_evt[g] & rise_sel[g])
                       | (cap_bus.fall_evt[g] & fall_sel[g]);
  end

  // write-one clears, a new edge wins over the clear
  // a process, not an assign: the strobe decode sits inside a function,
  // and only a process wakes on what a function reads beside its arguments
  always_comb begin
    next_pending = pending;
    if (wr_hit(OFF_PENDING)) begin
      next_pending = pending & ~i_wdata[LINE_COUNT-1:0];
    end
    next_pending = next_pending | edge_hit;
  end

  // pending holds until software clears it, whatever the masks
  always_ff @(posedge i_clk) begin
    if (i_rst) pending <= LINES_RST;
    else       pending <= next_pending;
  end

  // ==========================================================================
  // configuration registers
  // masks and trigger selects
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      int_mask <= LINES_RST;
      evt_mask <= LINES_RST;
      rise_sel <= LINES_RST;
      fall_sel <= LINES_RST;
    end else begin
      if (wr_hit(OFF_INT_MASK)) int_mask <= i_wdata[LINE_COUNT-1:0];
      if (wr_hit(OFF_EVT_MASK)) evt_mask <= i_wdata[LINE_COUNT-1:0];
      if (wr_hit(OFF_RISE_SEL)) rise_sel <= i_wdata[LINE_COUNT-1:0];
      if (wr_hit(OFF_FALL_SEL)) fall_sel <= i_wdata[LINE_COUNT-1:0];
    end
  end

  // pin group per external line
  // moving a line to a pin at another level shows up as one edge
  always_ff @(posedge i_clk) begin
    if (i_rst)                     port_sel <= WORD_RST;
    else if (wr_hit(OFF_PORT_SEL)) port_sel <= i_wdata;
  end

  // ==========================================================================
  // status and interrupt
  // sticky events, read clears, a set in the same cycle wins
  always_comb begin
    next_status = status;
    if (rd_hit(OFF_STATUS)) next_status = STAT_RST;
    next_status[STAT_OVERRUN] = next_status[STAT_OVERRUN] | (|(edge_hit & pending));
    next_status[STAT_REQUEST] = next_status[STAT_REQUEST]
                                | (|(edge_hit & (int_mask | evt_mask)));
  end

  // status mask as it stands after this edge
  always_comb begin
    next_stat_mask = stat_mask;
    if (wr_hit(OFF_STAT_MASK)) next_stat_mask = i_wdata[STAT_W-1:0];
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      status    <= STAT_RST;
      stat_mask <= STAT_RST;
    end else begin
      status    <= next_status;
      stat_mask <= next_stat_mask;
    end
  end

  // one level for all unmasked status bits, follows a mask write at once
  always_ff @(posedge i_clk) begin
    if (i_rst) o_irq <= 1'b0;
    else       o_irq <= |(next_status & next_stat_mask);
  end

  // ==========================================================================
  // request outputs
  // per-line interrupt levels, event pulses, wakeup level
  // line levels take a mask write one cycle late
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_line_irq <= LINES_RST;
      o_event    <= LINES_RST;
      o_wakeup   <= 1'b0;
    end else begin
      o_line_irq <= next_pending & int_mask;
      o_event    <= edge_hit & evt_mask;
      o_wakeup   <= (|(next_pending & int_mask)) | (|(edge_hit & evt_mask));
    end
  end

  // ==========================================================================
  // read port, data in the cycle after the strobe
  // unmapped and unaligned offsets answer zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= WORD_RST;
    end else if (i_rd) begin
      o_rdata <= WORD_RST;
      case (i_addr)
        OFF_INT_MASK:  o_rdata[LINE_COUNT-1:0] <= int_mask;
        OFF_EVT_MASK:  o_rdata[LINE_COUNT-1:0] <= evt_mask;
        OFF_RISE_SEL:  o_rdata[LINE_COUNT-1:0] <= rise_sel;
        OFF_FALL_SEL:  o_rdata[LINE_COUNT-1:0] <= fall_sel;
        OFF_PENDING:   o_rdata[LINE_COUNT-1:0] <= pending;
        OFF_PORT_SEL:  o_rdata <= port_sel;
        OFF_STATUS:    o_rdata[STAT_W-1:0] <= status;
        OFF_STAT_MASK: o_rdata[STAT_W-1:0] <= stat_mask;
        default:       o_rdata <= WORD_RST;  // unmapped reads zero
      endcase
    end else begin
      o_rdata <= WORD_RST;
    end
  end

endmodule : edge_line_event_controller

`default_nettype wire

// ---- hdl/elec_pkg.sv ----
package elec_pkg;

  // ==========================================================================
  // line counts
  localparam int LINE_COUNT = 19;            // total edge-detector lines
  localparam int EXT_LINES  = 16;            // lines fed from pins
  localparam int PIN_COUNT  = 51;            // pins that can reach the lines
  localparam int PORT_SEL_W = 2;             // pin group select per line

  // internal source line numbers
  localparam int LINE_SUPPLY = 16;           // supply_threshold_monitor
  localparam int LINE_ALARM  = 17;           // real-time alarm
  localparam int LINE_BUSWK  = 18;           // serial-bus wakeup

  // ==========================================================================
  // register map, byte addresses on the plain port
  localparam int ADDR_W   = 5;
  localparam int DATA_W   = 32;
  localparam logic [ADDR_W-1:0] OFF_INT_MASK  = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_EVT_MASK  = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_RISE_SEL  = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_FALL_SEL  = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_PENDING   = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_PORT_SEL  = 5'h14;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 5'h18;
  localparam logic [ADDR_W-1:0] OFF_STAT_MASK = 5'h1c;

  // status register layout
  localparam int STAT_W       = 2;
  localparam int STAT_OVERRUN = 0;           // edge on a line already pending
  localparam int STAT_REQUEST = 1;           // a request was forwarded

  // reset values
  localparam logic [LINE_COUNT-1:0] LINES_RST = 19'h00000;
  localparam logic [DATA_W-1:0]     WORD_RST  = 32'h00000000;
  localparam logic [STAT_W-1:0]     STAT_RST  = 2'h0;

endpackage : elec_pkg

// ---- hdl/capture_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// raw lines out to the capture stage, synchronised edge pulses back
interface capture_if #(parameter int N = 19);
  logic [N-1:0] line;                        // raw line levels
  logic [N-1:0] rise_evt;                    // one-cycle rise pulse
  logic [N-1:0] fall_evt;                    // one-cycle fall pulse

  modport ctrl (output line, input rise_evt, fall_evt);
  modport cap  (input line, output rise_evt, fall_evt);
endinterface : capture_if

`default_nettype wire

// ---- hdl/edge_capture.sv ----
`timescale 1ns/1ps
`default_nettype none

module edge_capture #(
  parameter int N = 19
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // lines and pulses
  capture_if.cap    cap
);

  // ==========================================================================
  // per-line capture and crossing
  for (genvar g = 0; g < N; g++) begin : g_line
    logic       rise_tog;
    logic       fall_tog;
    logic [2:0] rise_sync;
    logic [2:0] fall_sync;

    // toggles clocked by the line itself, so pulses of any width are held
    always_ff @(posedge cap.line[g] or posedge i_rst) begin
      if (i_rst) rise_tog <= 1'b0;
      else       rise_tog <= ~rise_tog;
    end

    always_ff @(negedge cap.line[g] or posedge i_rst) begin
      if (i_rst) fall_tog <= 1'b0;
      else       fall_tog <= ~fall_tog;
    end

    // two-flop synchroniser plus one history stage
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        rise_sync <= 3'h0;
        fall_sync <= 3'h0;
      end else begin
        rise_sync <= {rise_sync[1:0], rise_tog};
        fall_sync <= {fall_sync[1:0], fall_tog};
      end
    end

    // a toggle change becomes one clock pulse
    assign cap.rise_evt[g] = rise_sync[1] ^ rise_sync[2];
    assign cap.fall_evt[g] = fall_sync[1] ^ fall_sync[2];
  end

endmodule : edge_capture

`default_nettype wire

// ---- test/elec_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module elec_checker
  import elec_pkg::*;
(
  // watched ports
  input wire logic                  i_clk,
  input wire logic                  i_rst,
  input wire logic [ADDR_W-1:0]     i_addr,
  input wire logic                  i_wr,
  input wire logic                  i_rd,
  input wire logic [DATA_W-1:0]     o_rdata,
  input wire logic [LINE_COUNT-1:0] o_line_irq,
  input wire logic [LINE_COUNT-1:0] o_event,
  input wire logic                  o_wakeup,
  input wire logic                  o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ====
  // read port
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data outside answer");
  chk_rdata_odd: assert property (i_rd && i_addr[1:0] != 2'h0 |=> o_rdata == '0)
    else $error("unaligned read not zero");
  chk_upper_zero: assert property (i_rd && i_addr != OFF_PORT_SEL |=>
    o_rdata[DATA_W-1:LINE_COUNT] == '0) else $error("upper read bits set");
  // ====
  // requests
  chk_wake_equiv: assert property (o_wakeup == (|o_line_irq || |o_event))
    else $error("wakeup mismatch");
  chk_event_wakes: assert property (|o_event |-> o_wakeup)
    else $error("event without wakeup");
  chk_line_drop: assert property (|($past(o_line_irq) & ~o_line_irq) |->
    $past(i_wr) || $past(i_wr, 2)) else $error("line request dropped alone");
  chk_irq_fall: assert property ($fell(o_irq) |-> $past(i_rd) || $past(i_rd, 2)
    || $past(i_wr) || $past(i_wr, 2)) else $error("irq fell alone");
  chk_quiet_start: assert property ($fell(i_rst) |-> o_event == '0 && !o_irq && !o_wakeup)
    else $error("request right after reset");
endmodule : elec_checker

bind edge_line_event_controller elec_checker elec_checker_inst (.i_clk, .i_rst, .i_addr,
  .i_wr, .i_rd, .o_rdata, .o_line_irq, .o_event, .o_wakeup, .o_irq);
`default_nettype wire

// ---- test/line_source_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module line_source_model
  import elec_pkg::*;
(
  // source levels
  output logic [PIN_COUNT-1:0] o_gpio,
  output logic                 o_supply,
  output logic                 o_alarm,
  output logic                 o_bus
);
  logic [PIN_COUNT+2:0] lvl = '0;
  // pins, then the three internal sources
  assign o_gpio = lvl[PIN_COUNT-1:0];
  assign {o_bus, o_alarm, o_supply} = lvl[PIN_COUNT+2:PIN_COUNT];
  // level step, away from the clock edge
  task automatic step(input int idx, input logic v);
    #37 lvl[idx] = v;
  endtask : step
  // pulse shorter than one clock period
  task automatic glitch(input int idx);
    #37 lvl[idx] = ~lvl[idx];
    #30 lvl[idx] = ~lvl[idx];
  endtask : glitch
endmodule : line_source_model
`default_nettype wire

// ---- test/tb_edge_line_event_controller.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_edge_line_event_controller
  import elec_pkg::*;
;
  logic                  i_clk = 1'b0;
  logic                  i_rst;
  logic [ADDR_W-1:0]     i_addr = 5'h0;
  logic [DATA_W-1:0]     i_wdata = 32'h0;
  logic                  i_wr = 1'b0;
  logic                  i_rd = 1'b0;
  logic [DATA_W-1:0]     o_rdata;
  logic [PIN_COUNT-1:0]  gpio;
  logic                  sup, alm, bwk, o_wakeup, o_irq;
  logic [LINE_COUNT-1:0] o_line_irq, o_event;
  logic [LINE_COUNT-1:0] evt_seen = 19'h0;
  int                    err_count = 0;
  int                    samples_checked = 0;
  edge_line_event_controller #(.NUM_PINS(PIN_COUNT)) edge_line_event_controller_inst (
    .i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_gpio(gpio),
    .i_supply_monitor(sup), .i_rtc_alarm(alm), .i_bus_wakeup(bwk),
    .o_line_irq, .o_event, .o_wakeup, .o_irq);
  line_source_model line_source_model_inst (.o_gpio(gpio), .o_supply(sup),
    .o_alarm(alm), .o_bus(bwk));
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) evt_seen <= evt_seen | o_event;
  // ====
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask : rd_chk
  task automatic settle;
    repeat (6) @(posedge i_clk);
    #1; // look at outputs once they have settled
  endtask : settle
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  // ====
  // scenarios
  task automatic t_reset;
    for (int a = 0; a < 32; a += 4) begin
      rd_chk(5'(a), 32'h0);
    end
    rd_chk(5'h06, 32'h0);
  endtask : t_reset
  task automatic t_modes;
    for (int m = 1; m < 4; m++) begin
      wr(OFF_RISE_SEL, m[0] ? 32'h20 : 32'h0);
      wr(OFF_FALL_SEL, m[1] ? 32'h20 : 32'h0);
      line_source_model_inst.step(5, 1'b1);
      settle();
      rd_chk(OFF_PENDING, m[0] ? 32'h20 : 32'h0);
      wr(OFF_PENDING, 32'h0);
      rd_chk(OFF_PENDING, m[0] ? 32'h20 : 32'h0);
      wr(OFF_PENDING, 32'h20);
      line_source_model_inst.step(5, 1'b0);
      settle();
      rd_chk(OFF_PENDING, m[1] ? 32'h20 : 32'h0);
      wr(OFF_PENDING, 32'h20);
    end
  endtask : t_modes
  task automatic t_mask;
    wr(OFF_RISE_SEL, 32'h84);
    wr(OFF_INT_MASK, 32'h4);
    wr(OFF_EVT_MASK, 32'h80);
    line_source_model_inst.glitch(2);
    line_source_model_inst.glitch(7);
    settle();
    chk(32'(o_line_irq), 32'h4);
    chk(32'(evt_seen), 32'h80);
    chk(32'(o_event), 32'h0);
    rd_chk(OFF_PENDING, 32'h84);
    wr(OFF_PENDING, 32'h84);
    settle();
    chk(32'(o_line_irq), 32'h0);
  endtask : t_mask
  task automatic t_port;
    wr(OFF_PORT_SEL, 32'h80);
    wr(OFF_RISE_SEL, 32'h8);
    line_source_model_inst.step(3, 1'b1);
    settle();
    rd_chk(OFF_PENDING, 32'h0);
    line_source_model_inst.step(35, 1'b1);
    settle();
    rd_chk(OFF_PENDING, 32'h8);
    wr(OFF_PENDING, 32'h8);
  endtask : t_port
  task automatic t_internal;
    wr(OFF_RISE_SEL, 32'h70000);
    for (int i = 0; i < 3; i++) begin
      line_source_model_inst.step(PIN_COUNT + i, 1'b1);
      settle();
      rd_chk(OFF_PENDING, 32'h10000 << i);
      wr(OFF_PENDING, 32'h10000 << i);
    end
  endtask : t_internal
  task automatic t_status;
    rd_chk(OFF_STATUS, 32'h2);
    wr(OFF_STAT_MASK, 32'h3);
    wr(OFF_INT_MASK, 32'h10000);
    for (int k = 0; k < 2; k++) begin
      line_source_model_inst.step(PIN_COUNT, 1'b0);
      settle();
      line_source_model_inst.step(PIN_COUNT, 1'b1);
      settle();
      chk(32'(o_irq), 32'h1);
      chk(32'(o_wakeup), 32'h1);
    end
    rd_chk(OFF_STATUS, 32'h3);
    settle();
    chk(32'(o_irq), 32'h0);
    wr(OFF_PENDING, 32'h10000);
  endtask : t_status
  // ====
  // main sequence and watchdog
  initial begin
    i_rst <= 1'b1; // a real rising edge clears the line toggles
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_clk);
    t_reset();
    t_modes();
    t_mask();
    t_port();
    t_internal();
    t_status();
    tally_and_finish();
  end
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
endmodule : tb_edge_line_event_controller
`default_nettype wire
